// ==== common/profile_pkg.sv ====
`default_nettype none
package profile_pkg;
  // Register index space (printed offsets are word indices, so byte address = offset * 4)
  localparam int unsigned NUM_PROFILES = 6;
  localparam logic [15:0] PRIO_EN_BASE = 16'h1600;
  localparam logic [15:0] SOURCE_BASE = 16'h1601;
  localparam logic [15:0] PROFILE_STRIDE = 16'h0020;
  localparam logic [15:0] PROFILE_SPAN = 16'h0018;
  // Extra profile sets that mirror the first one
  localparam logic [15:0] EXTRA_SET_A = 16'h1680;
  localparam logic [15:0] EXTRA_SET_B = 16'h16A0;
  // Own registers: active profile status and input validity control
  localparam logic [15:0] STATUS_IDX = 16'h1700;
  localparam logic [15:0] VALID_IDX = 16'h1701;
  // Field layout
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned PRIO_LSB = 1;
  localparam int unsigned PRIO_W = 5;
  localparam int unsigned SRC_W = 5;
  localparam logic [4:0] PRIO_RESET = 5'h00;
  localparam logic [4:0] SRC_RESET = 5'h00;
  localparam logic [5:0] NONREVERT_WINDOW = 6'h07;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // One profile's stored configuration
  typedef struct packed {
    logic enable;
    logic [4:0] prio;
    logic [4:0] source;
  } profile_cfg_t;
  typedef enum logic [0:0] {LOOP_FREE, LOOP_LOCKED} loop_state_t;
endpackage
`default_nettype wire

// ==== hw/profile_regs.sv ====
// Contract
// [RULE_01] Extra profile sets mirror first set layout
// [RULE_02] Five-bit priority in bits 5:1, zero highest
// [RULE_03] Switch when higher priority differs by over seven
// [RULE_04] Stay when priority difference is zero to seven
// [RULE_05] Enable bit zero means profile never used; the code drops a just-disabled active profile one edge later
// [RULE_06] Source selector bits 4:0, upper bits reserved
// [RULE_07] Bits 7:6 of first register reserved zero
// [RULE_08] Software spaces revertive priorities by eight or more
`default_nettype none
module profile_regs
  import profile_pkg::*;
#(
  parameter int unsigned NPROF = NUM_PROFILES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Loop channel view
  output logic [4:0] ACTIVE_SOURCE,
  output logic ACTIVE_VALID
);
  // Stored profile configuration
  profile_cfg_t cfg [NPROF];
  // Which profiles software says are valid inputs
  logic [NPROF-1:0] valid_mask;
  // Selection state
  loop_state_t state;
  logic [2:0] active;
  // Latched address phase, then the combinational selection result
  logic wr_pend;
  logic [13:0] wr_idx;
  logic [2:0] next_active;
  logic next_found;
  // Distance from a profile's first register to its source register
  localparam logic [15:0] SRC_OFS = SOURCE_BASE - PRIO_EN_BASE;

  // Base index of profile n: first set at 0x1600, then the two extra sets
  // The extra sets are placed explicitly so a stride change cannot move them
  function automatic logic [15:0] base_of(input int unsigned n);
    logic [15:0] b;
    b = PRIO_EN_BASE + 16'(n) * PROFILE_STRIDE;
    if (n == 4) begin
      b = EXTRA_SET_A; // [RULE_01]
    end else if (n == 5) begin
      b = EXTRA_SET_B; // [RULE_01]
    end
    return b;
  endfunction

  // Byte address = index * 4; index is HADDR[15:2]
  wire logic [15:0] rd_idx = {2'h0, HADDR[15:2]};

  // Always zero-wait, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Capture write address phase
  // Write data arrives one cycle later, in the data phase
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend <= 1'b0;
      wr_idx <= 14'h0000;
    end else if (HREADY) begin
      wr_pend <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE;
      wr_idx <= HADDR[15:2];
    end
  end

  // Register writes; reserved bits are simply not stored
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NPROF; i++) begin
        cfg[i] <= '{enable: 1'b0, prio: PRIO_RESET, source: SRC_RESET}; // [RULE_01]
      end
      valid_mask <= '0;
    end else if (wr_pend) begin
      for (int i = 0; i < NPROF; i++) begin
        if ({2'h0, wr_idx} == base_of(i)) begin
          cfg[i].enable <= HWDATA[EN_BIT]; // [RULE_05]
          cfg[i].prio <= HWDATA[PRIO_LSB +: PRIO_W]; // [RULE_02]
        end else if ({2'h0, wr_idx} == base_of(i) + SRC_OFS) begin
          cfg[i].source <= HWDATA[SRC_W-1:0]; // [RULE_06]
        end
      end
      if ({2'h0, wr_idx} == VALID_IDX) begin
        valid_mask <= HWDATA[NPROF-1:0];
      end
    end
  end

  // Read data registered in the data phase
  // Limitation: a read right behind a write to the same register returns
  // the old value; the data phase would need a bypass to cover that case
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE) begin
      HRDATA <= 32'h0000_0000;
      for (int i = 0; i < NPROF; i++) begin
        if (rd_idx == base_of(i)) begin
          // Bits 7:6 read zero
          HRDATA <= {26'h0, cfg[i].prio, cfg[i].enable}; // [RULE_07]
        end else if (rd_idx == base_of(i) + SRC_OFS) begin
          // Bits 7:5 read zero
          HRDATA <= {27'h0, cfg[i].source}; // [RULE_06]
        end
      end
      if (rd_idx == STATUS_IDX) begin
        HRDATA <= {27'h0, state == LOOP_LOCKED, 1'b0, active};
      end else if (rd_idx == VALID_IDX) begin
        HRDATA <= {{(32-NPROF){1'b0}}, valid_mask};
      end
    end
  end

  // Pick the best eligible profile; lower number wins, lower index on ties
  // Disabled or invalid profiles never enter the race
  always_comb begin
    next_found = 1'b0;
    next_active = 3'h0;
    for (int i = 0; i < NPROF; i++) begin
      if (cfg[i].enable && valid_mask[i]) begin // [RULE_05]
        if (!next_found || cfg[i].prio < cfg[next_active].prio) begin
          next_found = 1'b1;
          next_active = 3'(i);
        end
      end
    end
  end

  // Loop selection: revertive only when priority gap exceeds seven
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= LOOP_FREE;
      active <= 3'h0;
    end else begin
      case (state)
        LOOP_FREE: begin
          if (next_found) begin
            state <= LOOP_LOCKED;
            active <= next_active;
          end
        end
        LOOP_LOCKED: begin
          if (!cfg[active].enable || !valid_mask[active]) begin
            // Lost the active profile: take the best remaining, if any
            state <= next_found ? LOOP_LOCKED : LOOP_FREE; // [RULE_05]
            active <= next_active;
          end else if (next_found && next_active != active &&
                       {1'b0, cfg[active].prio} > {1'b0, cfg[next_active].prio}
                       + NONREVERT_WINDOW) begin
            active <= next_active; // [RULE_03]
          end
          // Gap of 0 to 7 keeps the current profile [RULE_04]
        end
        default: state <= LOOP_FREE;
      endcase
    end
  end

  // Outputs to the loop channel
  // The source follows the active index through a mux of stored fields
  assign ACTIVE_VALID = state == LOOP_LOCKED;
  assign ACTIVE_SOURCE = cfg[active].source;

  // Assertions
  // A disabled profile may stay selected only in the cycle its enable falls
  a_no_disabled_use: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_05]
    ACTIVE_VALID |-> cfg[active].enable || !$stable(cfg[active].enable))
    else $error("disabled profile in use");

  // A gap above seven always moves to the better profile
  a_revert_gap: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_03]
    (state == LOOP_LOCKED && cfg[active].enable && valid_mask[active] && next_found &&
     {1'b0, cfg[active].prio} > {1'b0, cfg[next_active].prio} + NONREVERT_WINDOW)
    |=> active == $past(next_active))
    else $error("revertive switch missed");

  // A gap of zero to seven keeps the current profile
  a_nonrevert_hold: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_04]
    (state == LOOP_LOCKED && cfg[active].enable && valid_mask[active] &&
     {1'b0, cfg[active].prio} <= {1'b0, cfg[next_active].prio} + NONREVERT_WINDOW)
    |=> $stable(active))
    else $error("nonrevertive hold broken");

  // Bits 31:6 of every read, 7:6 of the first register included, always read zero
  a_prio_reserved: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_07]
    $past(HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE) |-> HRDATA[31:6] == 26'h0000000)
    else $error("reserved bits nonzero");

  // A write to the first profile's first register lands at the data phase end
  a_prio_write: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_02]
    (wr_pend && {2'h0, wr_idx} == PRIO_EN_BASE)
    |=> cfg[0].prio == $past(HWDATA[PRIO_LSB +: PRIO_W]) &&
        cfg[0].enable == $past(HWDATA[EN_BIT]))
    else $error("priority write lost");

  // The last extra set's source register has storage of its own
  a_extra_write: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_01]
    (wr_pend && {2'h0, wr_idx} == EXTRA_SET_B + SRC_OFS)
    |=> cfg[NPROF-1].source == $past(HWDATA[SRC_W-1:0]))
    else $error("extra set write lost");

  // From the free state the best enabled, valid profile is taken at once
  a_free_lock: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_05]
    (state == LOOP_FREE && next_found)
    |=> ACTIVE_VALID && active == $past(next_active) && $past(cfg[next_active].enable))
    else $error("free state did not lock");

  // A profile that loses its enable is dropped on the next edge
  a_lost_drop: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE_05]
    (state == LOOP_LOCKED && !cfg[active].enable)
    |=> !ACTIVE_VALID || active != $past(active))
    else $error("disabled profile kept");
endmodule
`default_nettype wire

// ==== sim/profile_regs_tb_top.sv ====
`default_nettype none
module profile_regs_tb_top;
  import profile_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Bus master side signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] rd;
  // Slave answers and loop channel view
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [4:0] act_src;
  wire logic act_valid;
  int error_cnt = 0;
  int n_checks = 0;

  // Single slave, so its ready is the bus ready
  profile_regs dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ACTIVE_SOURCE(act_src), .ACTIVE_VALID(act_valid));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Byte address of register r of profile n; extra sets come from their own constants
  function automatic logic [31:0] pa(input int n, input int r);
    logic [15:0] idx;
    idx = (n < 4) ? PRIO_EN_BASE + 16'(n) * PROFILE_STRIDE : (n == 4 ? EXTRA_SET_A : EXTRA_SET_B);
    return {14'h0, idx + 16'(r), 2'h0};
  endfunction

  // Counts and verdict, then stop
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for ready at a rising edge
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) return;
    end
    error_cnt++;
    $display("Error at %0t: ready never came", $time);
    results();
  endtask

  // One single transfer: address phase, then data phase; read data taken at its end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // Compare with four-state equality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int n = 0; n < NUM_PROFILES; n++) begin
      xfer(1'b0, pa(n, 0), 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, pa(n, 1), 32'h0);
      chk(rd, 32'h0);
    end
    xfer(1'b0, 32'h0000_0100, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, act_valid}, 32'h0);
    $display("Test reset values done");
    // Reserved bits must read zero after writing ones
    for (int n = 0; n < NUM_PROFILES; n++) begin
      xfer(1'b1, pa(n, 0), 32'hFF);
      xfer(1'b0, pa(n, 0), 32'h0);
      chk(rd, 32'h3F);
      xfer(1'b1, pa(n, 1), 32'hFF);
      xfer(1'b0, pa(n, 1), 32'h0);
      chk(rd, 32'h1F);
      xfer(1'b1, pa(n, 0), 32'h0);
    end
    $display("Test field access done");
    // Profile 1 prio 0x10, profile 0 prio 0x09, profile 2 disabled at prio 0
    xfer(1'b1, pa(1, 0), 32'h21);
    xfer(1'b1, pa(1, 1), 32'h05);
    xfer(1'b1, pa(0, 0), 32'h13);
    xfer(1'b1, pa(0, 1), 32'h03);
    xfer(1'b1, pa(2, 1), 32'h07);
    xfer(1'b1, {14'h0, VALID_IDX, 2'h0}, 32'h02);
    repeat (3) @(posedge clk);
    chk({26'h0, act_valid, act_src}, 32'h25);
    // Difference of seven and a disabled top profile: no move
    xfer(1'b1, {14'h0, VALID_IDX, 2'h0}, 32'h07);
    xfer(1'b0, {14'h0, VALID_IDX, 2'h0}, 32'h0);
    chk(rd, 32'h07);
    repeat (3) @(posedge clk);
    chk({26'h0, act_valid, act_src}, 32'h25);
    // Difference of eight: revert to profile 0
    xfer(1'b1, pa(0, 0), 32'h11);
    repeat (3) @(posedge clk);
    chk({26'h0, act_valid, act_src}, 32'h23);
    xfer(1'b0, {14'h0, STATUS_IDX, 2'h0}, 32'h0);
    chk(rd, 32'h10);
    // Disabling the active profile falls back to the enabled one
    xfer(1'b1, pa(0, 0), 32'h10);
    repeat (3) @(posedge clk);
    chk({26'h0, act_valid, act_src}, 32'h25);
    $display("Test selection done");
    // Reset in mid-run returns everything to defaults
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({26'h0, act_valid, act_src}, 32'h0);
    arst_n <= 1'b1;
    xfer(1'b0, pa(0, 0), 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, pa(5, 1), 32'h0);
    chk(rd, 32'h0);
    $display("Test reset in run done");
    results();
  end
endmodule
`default_nettype wire
